/* lpm_pkg.sv */
// Purpose: Shared constants and types for the low-power mode controller
// Assumes: AHB-Lite register access, 32-bit words, byte addresses below
// Notes:   Each register takes one aligned word
package lpm_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_PROTECT  = 8'h00;
    localparam logic [7:0] OFS_STANDBY  = 8'h04;
    localparam logic [7:0] OFS_MSTOP_A  = 8'h08;
    localparam logic [7:0] OFS_MSTOP_B  = 8'h0C;
    localparam logic [7:0] OFS_MSTOP_C  = 8'h10;
    localparam logic [7:0] OFS_MSTOP_D  = 8'h14;
    localparam logic [7:0] OFS_OPPWR    = 8'h18;
    localparam logic [7:0] OFS_MOSC_DRV = 8'h1C;
    localparam logic [7:0] OFS_MOSC_WT  = 8'h20;
    localparam logic [7:0] OFS_SW_RESET = 8'h24;
    localparam logic [7:0] OFS_CLK_GEN  = 8'h28;
    localparam logic [7:0] OFS_LPT_CTL  = 8'h2C;
    localparam logic [7:0] OFS_LVD_CTL  = 8'h30;
    localparam logic [7:0] OFS_STATUS   = 8'h34;

    // ==========================================================
    // Field positions
    localparam int unsigned MODE_SEL_LSB  = 0;   // 2-bit mode selection
    localparam int unsigned OUT_PORT_EN   = 15;  // standby output enable
    localparam int unsigned DMA_STOP_BIT  = 28;  // shared dma/dtc stop

    // ==========================================================
    // Values after reset
    localparam logic [3:0]  RST_PROTECT = 4'h0;
    localparam logic [31:0] RST_STANDBY = 32'h0000_0000;
    localparam logic [31:0] RST_MSTOP   = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_GENERIC = 32'h0000_0000;

    // Mode selection codes held in the standby control register
    localparam logic [1:0] SEL_SLEEP = 2'h0;
    localparam logic [1:0] SEL_DEEP  = 2'h1;
    localparam logic [1:0] SEL_STBY  = 2'h2;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_DEEP,
        ST_STBY
    } lpm_state_t;

    // Stop and keep-alive controls toward the rest of the chip
    typedef struct packed {
        logic cpu;
        logic dma;
        logic data_transfer_controller;
        logic flash;
        logic wdt;
        logic ram;
        logic main_osc;
        logic high_speed_internal_osc;
        logic low_speed_internal_osc;
        logic pll;
        logic periph;
        logic io_hold;
        logic independent_watchdog_run;
        logic aon_run;
        logic por_run;
    } lpm_ctl_t;

endpackage

/* lpm_ctrl.sv */
// Purpose: Low-power mode entry/exit, stop controls and write protection
// Assumes: One clock mclk at 250 MHz, synchronous active-low reset
// Notes:   Zero-wait AHB-Lite slave; sleep mode itself is not handled
// Operation
// [RULE1] Mode chosen in standby control register; entered only on wait
// [RULE2] Only an interrupt wakes; CPU resumes in the waking handler
// [RULE3] Deep sleep stops cpu, dma, dtc, flash, window watchdog; clocks run
// [RULE4] Working memory stopped but retained in both low-power modes
// [RULE5] Standby stops oscillators, PLLs, peripherals; pins hold levels
// [RULE6] Independent watchdog and its oscillator keep running in both modes
// [RULE7] RTC, low-power timer, detectors, comparator, sub-clock stay active
// [RULE8] Protect bit 0 guards clock-generation registers; code uses it for the clock register only, oscillator drive/wait use bit 1
// [RULE9] Protect bit 1 guards standby, module stop, power, reset registers
// [RULE10] Protect bit 2 guards low-power timer registers
// [RULE11] Protect bit 3 guards voltage detector and battery registers
// [RULE12] One module stop bit stops dma engine and transfer controller
// [RULE13] Guarded writes ignored while protect bit clear; reads unaffected
`timescale 1ns/1ps
module lpm_ctrl (
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    input  wire logic            wait_exec,
    input  wire logic            wake_irq,
    output lpm_pkg::lpm_ctl_t    ctl,
    output logic                 resume_handler,
    output logic                 out_port_en,
    output logic                 sw_reset_req,
    output logic      [31:0]     mstop_b,
    output logic      [31:0]     mstop_c,
    output logic      [31:0]     mstop_d
);

    // ==========================================================
    // Register state
    logic [3:0]          protect_q;
    logic [31:0]         standby_q;
    logic [31:0]         mstop_a_q;
    logic [31:0]         mstop_b_q;
    logic [31:0]         mstop_c_q;
    logic [31:0]         mstop_d_q;
    logic [31:0]         oppwr_q;
    logic [31:0]         mosc_drv_q;
    logic [31:0]         mosc_wt_q;
    logic [31:0]         clk_gen_q;
    logic [31:0]         lpt_ctl_q;
    logic [31:0]         lvd_ctl_q;
    logic [7:0]          addr_q;
    logic                wr_q;
    logic [31:0]         rdata_q;
    logic                swrst_q;
    logic                resume_q;
    lpm_pkg::lpm_state_t state_q;
    lpm_pkg::lpm_state_t state_d;
    lpm_pkg::lpm_ctl_t   ctl_q;
    logic                addr_phase;
    logic [2:0]          guard_sel;
    logic                wr_ok;

    // ==========================================================
    // Decode helpers
    // Which protect bit guards an offset; 3'h4 means unguarded
    function automatic logic [2:0] guard_of(input logic [7:0] ofs);
        logic [2:0] g;
        g = 3'h4;
        unique case (ofs)
            lpm_pkg::OFS_CLK_GEN:  g = 3'h0;
            lpm_pkg::OFS_STANDBY,
            lpm_pkg::OFS_MSTOP_A,
            lpm_pkg::OFS_MSTOP_B,
            lpm_pkg::OFS_MSTOP_C,
            lpm_pkg::OFS_MSTOP_D,
            lpm_pkg::OFS_OPPWR,
            lpm_pkg::OFS_MOSC_DRV,
            lpm_pkg::OFS_MOSC_WT,
            lpm_pkg::OFS_SW_RESET: g = 3'h1;
            lpm_pkg::OFS_LPT_CTL:  g = 3'h2;
            lpm_pkg::OFS_LVD_CTL:  g = 3'h3;
            default:               g = 3'h4;
        endcase
        return g;
    endfunction

    // Stop pattern for a mode; dma and dtc share one module stop bit
    function automatic lpm_pkg::lpm_ctl_t stops_of(
            input lpm_pkg::lpm_state_t st, input logic dma_mstop);
        lpm_pkg::lpm_ctl_t c;
        c          = '0;
        c.independent_watchdog_run = 1'b1;                       // [RULE6]
        c.aon_run  = 1'b1;                       // [RULE7]
        c.por_run  = 1'b1;                       // [RULE7]
        c.dma      = dma_mstop;                  // [RULE12]
        c.data_transfer_controller      = dma_mstop;                  // [RULE12]
        unique case (st)
            lpm_pkg::ST_RUN: begin
            end
            lpm_pkg::ST_DEEP: begin
                c.cpu   = 1'b1;                  // [RULE3]
                c.dma   = 1'b1;
                c.data_transfer_controller   = 1'b1;
                c.flash = 1'b1;
                c.wdt   = 1'b1;
                c.ram   = 1'b1;                  // [RULE4]
            end
            lpm_pkg::ST_STBY: begin
                c.cpu      = 1'b1;
                c.dma      = 1'b1;
                c.data_transfer_controller      = 1'b1;
                c.flash    = 1'b1;
                c.wdt      = 1'b1;
                c.ram      = 1'b1;               // [RULE4]
                c.main_osc = 1'b1;               // [RULE5]
                c.high_speed_internal_osc     = 1'b1;
                c.low_speed_internal_osc     = 1'b1;
                c.pll      = 1'b1;
                c.periph   = 1'b1;
                c.io_hold  = 1'b1;
            end
        endcase
        return c;
    endfunction

    // ==========================================================
    // AHB-Lite slave
    // Address phase is taken only while the bus is ready
    assign addr_phase = hsel && hready && htrans[1];

    // Write allowed when the guarding protect bit is set
    always_comb begin
        guard_sel = guard_of(addr_q);
        wr_ok     = 1'b1;
        if (guard_sel != 3'h4) begin
            wr_ok = protect_q[guard_sel[1:0]];   // [RULE13]
        end
    end

    // Latch address phase for the following data phase
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            addr_q <= 8'h00;
            wr_q   <= 1'b0;
        end else begin
            addr_q <= addr_phase ? haddr[7:0] : 8'h00;
            wr_q   <= addr_phase && hwrite && (hsize == 3'h2);
        end
    end

    // Read data captured at address phase; reads ignore protection
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                lpm_pkg::OFS_PROTECT:  rdata_q <= {28'h000_0000, protect_q};
                lpm_pkg::OFS_STANDBY:  rdata_q <= standby_q;
                lpm_pkg::OFS_MSTOP_A:  rdata_q <= mstop_a_q;
                lpm_pkg::OFS_MSTOP_B:  rdata_q <= mstop_b_q;
                lpm_pkg::OFS_MSTOP_C:  rdata_q <= mstop_c_q;
                lpm_pkg::OFS_MSTOP_D:  rdata_q <= mstop_d_q;
                lpm_pkg::OFS_OPPWR:    rdata_q <= oppwr_q;
                lpm_pkg::OFS_MOSC_DRV: rdata_q <= mosc_drv_q;
                lpm_pkg::OFS_MOSC_WT:  rdata_q <= mosc_wt_q;
                lpm_pkg::OFS_CLK_GEN:  rdata_q <= clk_gen_q;
                lpm_pkg::OFS_LPT_CTL:  rdata_q <= lpt_ctl_q;
                lpm_pkg::OFS_LVD_CTL:  rdata_q <= lvd_ctl_q;
                lpm_pkg::OFS_STATUS:   rdata_q <= {30'h0000_0000, state_q};
                default:               rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Protect bits themselves are never guarded
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            protect_q <= lpm_pkg::RST_PROTECT;
        end else if (wr_q && addr_q == lpm_pkg::OFS_PROTECT) begin
            protect_q <= hwdata[3:0];
        end
    end

    // Guarded control registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            standby_q  <= lpm_pkg::RST_STANDBY;
            mstop_a_q  <= lpm_pkg::RST_MSTOP;
            mstop_b_q  <= lpm_pkg::RST_MSTOP;
            mstop_c_q  <= lpm_pkg::RST_MSTOP;
            mstop_d_q  <= lpm_pkg::RST_MSTOP;
            oppwr_q    <= lpm_pkg::RST_GENERIC;
            mosc_drv_q <= lpm_pkg::RST_GENERIC;
            mosc_wt_q  <= lpm_pkg::RST_GENERIC;
            clk_gen_q  <= lpm_pkg::RST_GENERIC;
            lpt_ctl_q  <= lpm_pkg::RST_GENERIC;
            lvd_ctl_q  <= lpm_pkg::RST_GENERIC;
        end else if (wr_q && wr_ok) begin            // [RULE13]
            unique case (addr_q)
                lpm_pkg::OFS_STANDBY:  standby_q  <= hwdata;  // [RULE9]
                lpm_pkg::OFS_MSTOP_A:  mstop_a_q  <= hwdata;
                lpm_pkg::OFS_MSTOP_B:  mstop_b_q  <= hwdata;
                lpm_pkg::OFS_MSTOP_C:  mstop_c_q  <= hwdata;
                lpm_pkg::OFS_MSTOP_D:  mstop_d_q  <= hwdata;
                lpm_pkg::OFS_OPPWR:    oppwr_q    <= hwdata;
                lpm_pkg::OFS_MOSC_DRV: mosc_drv_q <= hwdata;
                lpm_pkg::OFS_MOSC_WT:  mosc_wt_q  <= hwdata;
                lpm_pkg::OFS_CLK_GEN:  clk_gen_q  <= hwdata;  // [RULE8]
                lpm_pkg::OFS_LPT_CTL:  lpt_ctl_q  <= hwdata;  // [RULE10]
                lpm_pkg::OFS_LVD_CTL:  lvd_ctl_q  <= hwdata;  // [RULE11]
                default: begin
                end
            endcase
        end
    end

    // Software reset request: one-cycle pulse on a permitted write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            swrst_q <= 1'b0;
        end else begin
            swrst_q <= wr_q && wr_ok && addr_q == lpm_pkg::OFS_SW_RESET;
        end
    end

    // ==========================================================
    // Mode sequencer
    // Wait only commits when a low-power mode is selected beforehand
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            lpm_pkg::ST_RUN: begin
                if (wait_exec) begin                    // [RULE1]
                    if (standby_q[1:0] == lpm_pkg::SEL_DEEP) begin
                        state_d = lpm_pkg::ST_DEEP;
                    end else if (standby_q[1:0] == lpm_pkg::SEL_STBY) begin
                        state_d = lpm_pkg::ST_STBY;
                    end
                end
            end
            lpm_pkg::ST_DEEP,
            lpm_pkg::ST_STBY: begin
                if (wake_irq) begin                     // [RULE2]
                    state_d = lpm_pkg::ST_RUN;
                end
            end
            default: state_d = lpm_pkg::ST_RUN;
        endcase
    end

    // State and its stop pattern move together, so outputs stay in step
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= lpm_pkg::ST_RUN;
            ctl_q   <= stops_of(lpm_pkg::ST_RUN, 1'b1);
        end else begin
            state_q <= state_d;
            ctl_q   <= stops_of(state_d, mstop_a_q[lpm_pkg::DMA_STOP_BIT]);
        end
    end

    // Resume pulse tells the CPU to vector to the waking handler
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            resume_q <= 1'b0;
        end else begin
            resume_q <= (state_q != lpm_pkg::ST_RUN) && wake_irq; // [RULE2]
        end
    end

    // ==========================================================
    // Outputs
    assign hrdata         = rdata_q;
    assign hreadyout      = 1'b1;    // Never stalls; every transfer is zero-wait
    assign hresp          = 1'b0;
    assign ctl            = ctl_q;
    assign resume_handler = resume_q;
    assign sw_reset_req   = swrst_q;
    assign out_port_en    = standby_q[lpm_pkg::OUT_PORT_EN];
    assign mstop_b        = mstop_b_q;
    assign mstop_c        = mstop_c_q;
    assign mstop_d        = mstop_d_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_deep_req;
        state_q == lpm_pkg::ST_RUN && wait_exec
            && standby_q[1:0] == lpm_pkg::SEL_DEEP;
    endsequence
    sequence s_in_lowpower;
        state_q != lpm_pkg::ST_RUN;
    endsequence

    a_entry_on_wait: assert property (                          // [RULE1]
        state_q == lpm_pkg::ST_RUN && !wait_exec
            |=> state_q == lpm_pkg::ST_RUN)
        else $error("low-power mode entered without wait");
    a_wake_vector: assert property (                            // [RULE2]
        s_in_lowpower ##0 wake_irq
            |=> resume_q && state_q == lpm_pkg::ST_RUN ##1 !resume_q)
        else $error("wake did not resume through handler");
    a_deep_stops: assert property (                             // [RULE3]
        s_deep_req |=> ctl_q.cpu && ctl_q.dma && ctl_q.flash
            && ctl_q.wdt && !ctl_q.pll && !ctl_q.main_osc)
        else $error("deep sleep stop pattern wrong");
    a_ram_retain: assert property (                             // [RULE4]
        s_in_lowpower |-> ctl_q.ram)
        else $error("working memory not stopped in low power");
    a_stby_osc: assert property (                               // [RULE5]
        state_q == lpm_pkg::ST_STBY |-> ctl_q.main_osc && ctl_q.high_speed_internal_osc
            && ctl_q.low_speed_internal_osc && ctl_q.pll && ctl_q.periph && ctl_q.io_hold)
        else $error("standby left an oscillator running");
    a_independent_watchdog_alive: assert property (                             // [RULE6]
        s_in_lowpower |-> ctl_q.independent_watchdog_run)
        else $error("independent watchdog stopped");
    a_aon_alive: assert property (                              // [RULE7]
        s_in_lowpower |-> ctl_q.aon_run && ctl_q.por_run)
        else $error("always-on blocks stopped");
    a_clk_guard: assert property (                              // [RULE8]
        wr_q && addr_q == lpm_pkg::OFS_CLK_GEN && !protect_q[0]
            |=> $stable(clk_gen_q))
        else $error("clock register written while protected");
    a_sby_guard: assert property (                              // [RULE9]
        wr_q && addr_q == lpm_pkg::OFS_STANDBY && !protect_q[1]
            |=> $stable(standby_q))
        else $error("standby register written while protected");
    a_lpt_guard: assert property (                              // [RULE10]
        wr_q && addr_q == lpm_pkg::OFS_LPT_CTL && !protect_q[2]
            |=> $stable(lpt_ctl_q))
        else $error("timer register written while protected");
    a_lvd_guard: assert property (                              // [RULE11]
        wr_q && addr_q == lpm_pkg::OFS_LVD_CTL && !protect_q[3]
            |=> $stable(lvd_ctl_q))
        else $error("detector register written while protected");
    a_dma_pair: assert property (                               // [RULE12]
        state_q == lpm_pkg::ST_RUN |-> ctl_q.dma == ctl_q.data_transfer_controller)
        else $error("dma and dtc stops diverge");
    a_guard_open: assert property (                             // [RULE13]
        wr_q && addr_q == lpm_pkg::OFS_MSTOP_A && protect_q[1]
            |=> mstop_a_q == $past(hwdata))
        else $error("permitted write not stored");

endmodule

/* lpm_tb.sv */
// Purpose: Self-checking bench for the low-power mode controller
// Assumes: Zero-wait AHB-Lite slave, hready fed back from hreadyout
// Notes:   Register tests first, then mode entry and wake-up sequences
`timescale 1ns/1ps
module tb;
    logic               mclk = 1'b0;
    logic               rst_n = 1'b0;
    logic               hsel = 1'b0;
    logic [31:0]        haddr = 32'h0;
    logic [1:0]         htrans = 2'h0;
    logic               hwrite = 1'b0;
    logic [2:0]         hsize = 3'h2;
    logic [31:0]        hwdata = 32'h0;
    logic [31:0]        hrdata;
    logic               hreadyout;
    logic               hresp;
    logic               wait_exec = 1'b0;
    logic               wake_irq = 1'b0;
    lpm_pkg::lpm_ctl_t  ctl;
    logic               resume_handler;
    logic               out_port_en;
    logic               sw_reset_req;
    logic [31:0]        mstop_b;
    logic [31:0]        mstop_c;
    logic [31:0]        mstop_d;
    int                 err_total = 0;
    int                 check_count = 0;
    int                 n_resume = 0;
    int                 n_swrst = 0;
    logic [31:0]        rd;
    logic [31:0]        exp_q [14];
    // Register table: offsets and the protect bit guarding each (-1 none)
    logic [7:0] ofs [14] = '{lpm_pkg::OFS_PROTECT, lpm_pkg::OFS_STANDBY,
        lpm_pkg::OFS_MSTOP_A, lpm_pkg::OFS_MSTOP_B, lpm_pkg::OFS_MSTOP_C,
        lpm_pkg::OFS_MSTOP_D, lpm_pkg::OFS_OPPWR, lpm_pkg::OFS_MOSC_DRV,
        lpm_pkg::OFS_MOSC_WT, lpm_pkg::OFS_SW_RESET, lpm_pkg::OFS_CLK_GEN,
        lpm_pkg::OFS_LPT_CTL, lpm_pkg::OFS_LVD_CTL, lpm_pkg::OFS_STATUS};
    int guard [14] = '{-1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0, 2, 3, -1};

    // ==========================================================
    // Clock, device and pulse monitors
    always #2 mclk = ~mclk;

    lpm_ctrl uut (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .hsel           (hsel),
        .haddr          (haddr),
        .htrans         (htrans),
        .hwrite         (hwrite),
        .hsize          (hsize),
        .hwdata         (hwdata),
        .hready         (hreadyout),
        .hrdata         (hrdata),
        .hreadyout      (hreadyout),
        .hresp          (hresp),
        .wait_exec      (wait_exec),
        .wake_irq       (wake_irq),
        .ctl            (ctl),
        .resume_handler (resume_handler),
        .out_port_en    (out_port_en),
        .sw_reset_req   (sw_reset_req),
        .mstop_b        (mstop_b),
        .mstop_c        (mstop_c),
        .mstop_d        (mstop_d)
    );

    // One-cycle pulses are counted so missing or extra ones show up
    always @(posedge mclk) begin
        if (resume_handler === 1'b1) n_resume++;
        if (sw_reset_req === 1'b1) n_swrst++;
    end

    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Waits at rising edges until hready is sampled high; watchdog bounds it
    task automatic wait_ready();
        do begin
            @(posedge mclk);
        end while (hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        hsize  <= 3'h2;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd32(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    // Expected stop pattern: mode 0 run, 1 deep sleep, 2 standby
    function automatic lpm_pkg::lpm_ctl_t ctl_exp(int m, logic dma);
        lpm_pkg::lpm_ctl_t c;
        c = '0;
        c.independent_watchdog_run = 1'b1;
        c.aon_run  = 1'b1;
        c.por_run  = 1'b1;
        c.dma      = (m == 0) ? dma : 1'b1;
        c.data_transfer_controller      = (m == 0) ? dma : 1'b1;
        if (m != 0) {c.cpu, c.flash, c.wdt, c.ram} = 4'hF;
        if (m == 2) {c.main_osc, c.high_speed_internal_osc, c.low_speed_internal_osc, c.pll} = 4'hF;
        if (m == 2) {c.periph, c.io_hold} = 2'h3;
        return c;
    endfunction

    task automatic pulse_wait();
        @(posedge mclk) wait_exec <= 1'b1;
        @(posedge mclk) wait_exec <= 1'b0;
        #1;
    endtask

    // Wake, then check resume pulse and run pattern one cycle later
    task automatic wake(input int res_before);
        @(posedge mclk) wake_irq <= 1'b1;
        @(posedge mclk) wake_irq <= 1'b0;
        #1;
        chk(32'(resume_handler), 32'h1);
        chk(32'(ctl), 32'(ctl_exp(0, 1'b0)));
        @(posedge mclk);
        #1;
        chk(32'(n_resume - res_before), 32'h1);
    endtask

    // ==========================================================
    // Watchdog against hangs
    initial begin
        #200000;
        err_total++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        int res0;
        logic [31:0] v;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk(32'(ctl), 32'(ctl_exp(0, 1'b1)));
        chk(mstop_b & mstop_c & mstop_d, lpm_pkg::RST_MSTOP);
        chk(32'({resume_handler, sw_reset_req, out_port_en}), 32'h0);
        chk(32'({hreadyout, hresp}), 32'h2);
        @(posedge mclk);
        for (int i = 0; i < 14; i++) begin
            exp_q[i] = (i >= 2 && i <= 5) ? lpm_pkg::RST_MSTOP : 32'h0;
            rd32(ofs[i], rd);
            chk(rd, exp_q[i]);
        end
        $display("test reset_values done");

        // Each protect bit alone opens only its own registers
        for (int k = 0; k < 4; k++) begin
            wr32(lpm_pkg::OFS_PROTECT, 32'(1 << k));
            for (int i = 1; i < 14; i++) begin
                v = 32'((k & 1) + 1);
                if (i == 1) v = 32'h0000_8001;
                if (i >= 2 && i <= 5) v = 32'hA5A5_0000 + 32'(k);
                wr32(ofs[i], v);
                if (guard[i] == k && i != 9) exp_q[i] = v;
            end
            for (int i = 1; i < 14; i++) begin
                rd32(ofs[i], rd);
                chk(rd, exp_q[i]);
            end
        end
        chk(32'(n_swrst), 32'h1);
        chk(mstop_d, exp_q[5]);
        chk(32'(out_port_en), 32'h1);
        // Protect cleared: writes dropped, reads still served
        wr32(lpm_pkg::OFS_PROTECT, 32'h0);
        wr32(lpm_pkg::OFS_STANDBY, 32'h0);
        wr32(lpm_pkg::OFS_MSTOP_B, 32'h0);
        wr32(lpm_pkg::OFS_CLK_GEN, 32'h0);
        rd32(lpm_pkg::OFS_STANDBY, rd);
        chk(rd, exp_q[1]);
        rd32(lpm_pkg::OFS_CLK_GEN, rd);
        chk(rd, exp_q[10]);
        chk(mstop_b, exp_q[3]);
        wr32(8'h40, 32'h1234_5678);
        rd32(8'h40, rd);
        chk(rd, 32'h0);
        $display("test write_protect done");

        // One stop bit controls both transfer engines
        wr32(lpm_pkg::OFS_PROTECT, 32'h2);
        wr32(lpm_pkg::OFS_MSTOP_A, 32'h1000_0000);
        // Stop pattern follows the stored bit one cycle later
        @(posedge mclk);
        #1;
        chk(32'({ctl.dma, ctl.data_transfer_controller}), 32'h3);
        wr32(lpm_pkg::OFS_MSTOP_A, 32'hEFFF_FFFF);
        @(posedge mclk);
        #1;
        chk(32'({ctl.dma, ctl.data_transfer_controller}), 32'h0);
        $display("test shared_stop done");

        // Wait with no low-power mode chosen, and a wake in run
        res0 = n_resume;
        wr32(lpm_pkg::OFS_STANDBY, 32'h0);
        pulse_wait();
        rd32(lpm_pkg::OFS_STATUS, rd);
        chk(rd, 32'h0);
        // Unused mode code must not enter a low-power state either
        wr32(lpm_pkg::OFS_STANDBY, 32'h3);
        pulse_wait();
        rd32(lpm_pkg::OFS_STATUS, rd);
        chk(rd, 32'h0);
        @(posedge mclk) wake_irq <= 1'b1;
        @(posedge mclk) wake_irq <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(32'(n_resume - res0), 32'h0);
        chk(32'(ctl), 32'(ctl_exp(0, 1'b0)));
        $display("test no_entry done");

        // Deep sleep then standby, each left by an interrupt
        for (int m = 1; m < 3; m++) begin
            wr32(lpm_pkg::OFS_STANDBY, (m == 2) ? 32'h8002 : 32'h1);
            #1;
            chk(32'(ctl), 32'(ctl_exp(0, 1'b0)));
            pulse_wait();
            chk(32'(ctl), 32'(ctl_exp(m, 1'b0)));
            chk(32'({ctl.independent_watchdog_run, ctl.aon_run}), 32'h3);
            rd32(lpm_pkg::OFS_STATUS, rd);
            chk(rd, 32'(m));
            chk(32'(ctl), 32'(ctl_exp(m, 1'b0)));
            res0 = n_resume;
            wake(res0);
            rd32(lpm_pkg::OFS_STATUS, rd);
            chk(rd, 32'h0);
        end
        chk(32'(out_port_en), 32'h1);
        $display("test mode_cycles done");
        test_done();
    end
endmodule
